/* File: verilog/fdc_cmd_pkg.sv */
// constants for the floppy command engine: codes, result layouts, reset values
package fdc_cmd_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_DATA    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_DRVCTL  = 8'h08;
	localparam logic [7:0] OFS_SEEKRES = 8'h0c;
	localparam logic [7:0] OFS_DRVSTAT = 8'h10;
	// main status bit positions
	localparam int MS_RQM  = 7;
	localparam int MS_DIO  = 6;
	localparam int MS_BUSY = 4;
	// command codes on bits 4:0 of the first byte
	localparam logic [4:0] CODE_READ_ID  = 5'h0a;
	localparam logic [4:0] CODE_DUMP     = 5'h0e;
	localparam logic [4:0] CODE_LOCK     = 5'h14;
	localparam logic [4:0] CODE_FORMAT   = 5'h0d;
	localparam logic [4:0] CODE_CONFIG   = 5'h13;
	localparam logic [4:0] CODE_SPECIFY  = 5'h03;
	localparam logic [4:0] CODE_RD_DATA  = 5'h06;
	localparam logic [4:0] CODE_RD_DEL   = 5'h0c;
	localparam logic [4:0] CODE_WR_DATA  = 5'h05;
	localparam logic [4:0] CODE_WR_DEL   = 5'h09;
	localparam logic [4:0] CODE_RD_TRACK = 5'h02;
	localparam logic [4:0] CODE_VER      = 5'h16;
	// parameter and result byte counts
	localparam logic [3:0] XFER_PARAMS   = 4'h8;
	localparam logic [3:0] XFER_RESULTS  = 4'h7;
	localparam logic [3:0] READID_PARAMS = 4'h1;
	localparam logic [3:0] DUMP_RESULTS  = 4'ha;
	localparam logic [3:0] CONFIG_PARAMS = 4'h3;
	localparam logic [3:0] SPEC_PARAMS   = 4'h2;
	localparam logic [3:0] FMT_PARAMS    = 4'h5;
	// status byte values, lock result bit and implied seek config bit positions
	localparam logic [7:0] RES0_INVALID  = 8'h80;
	localparam logic [7:0] RES0_ABNORMAL = 8'h40;
	localparam int         LOCK_BIT_POS  = 4;
	localparam int         ISEEK_BIT_POS = 6;
	// one step of the implied seek, in ns and in cycles
	localparam int         CLK_PERIOD_NS = 4;
	localparam int         STEP_NS       = 400;
	localparam logic [7:0] STEP_CYC      = 8'(STEP_NS / CLK_PERIOD_NS);
	// reset values
	localparam logic [7:0] SPEC1_RST     = 8'h00;
	localparam logic [7:0] SPEC2_RST     = 8'h00;
	localparam logic [7:0] CFG_RST       = 8'h20;
	localparam logic [7:0] PRETRK_RST    = 8'h00;
	localparam logic [7:0] PERP_RST      = 8'h00;
endpackage

/* File: verilog/seek_unit.sv */
// seek sequencer that steps a present-cylinder value toward a target
`timescale 1ns/100ps
`default_nettype none
module seek_unit
	import fdc_cmd_pkg::*;
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	// request
	input  wire logic       start_in,
	input  wire logic [7:0] from_cyl_in,
	input  wire logic [7:0] to_cyl_in,
	input  wire logic       fault_in,
	// outcome
	output logic            busy_out,
	output logic            done_out,
	output logic            fail_out,
	output logic [7:0]      cyl_out
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [7:0] cyl_ff;
	logic [7:0] nxt_cyl;
	logic       busy_ff;
	logic       nxt_busy;
	logic       done_ff;
	logic       nxt_done;
	logic       fail_ff;
	logic       nxt_fail;

	always_comb
	begin
		nxt_cnt  = cnt_ff;
		nxt_cyl  = cyl_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_fail = fail_ff;
		if (start_in)
		begin
			nxt_busy = 1'b1;
			nxt_cyl  = from_cyl_in;
			nxt_cnt  = STEP_CYC;
			nxt_fail = 1'b0;
		end
		else if (busy_ff)
		begin
			if (fault_in)
			begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				nxt_fail = 1'b1;
			end
			else if (cyl_ff == to_cyl_in)
			begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
			else if (cnt_ff == 8'h01)
			begin
				nxt_cnt = STEP_CYC;
				nxt_cyl = (cyl_ff < to_cyl_in) ? cyl_ff + 8'h01 : cyl_ff - 8'h01;
			end
			else
			begin
				nxt_cnt = cnt_ff - 8'h01;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt_ff  <= 8'h00;
			cyl_ff  <= 8'h00;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
		end
		else
		begin
			cnt_ff  <= nxt_cnt;
			cyl_ff  <= nxt_cyl;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			fail_ff <= nxt_fail;
		end
	end

	assign busy_out = busy_ff;
	assign done_out = done_ff;
	assign fail_out = fail_ff;
	assign cyl_out  = cyl_ff;
endmodule
`default_nettype wire

/* File: verilog/floppy_cmd_seek_dump_logic.sv */
// command engine: byte protocol, register dump, read id, transfers with implied seek
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RQ1: count byte: sectors after format, else end sector
// RQ2: internal unit select never drives select pins
// RQ3: host keeps unit select matching drive control; the block never compares the two
// RQ4: transfer commands share parameters and results
// RQ5: implied seek before transfer when enabled
// RQ6: implied seek needs no extra host action
// RQ7: selected drive busy bit during seek
// RQ8: seek failure reported in normal results
// RQ9: read id returns seven ordered result bytes
// RQ10: undefined code returns one invalid status
// RQ11: lock answer echoes lock bit at four
module floppy_cmd_seek_dump_logic
	import fdc_cmd_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// drive pins
	input  wire logic        seek_fault_in,
	output logic [1:0]       drive_select_out
);
	typedef enum {S_IDLE, S_PARAM, S_SEEK, S_RESULT} phase_e;
	phase_e      phase_ff;
	phase_e      nxt_phase;
	logic [7:0]  cmd_ff;
	logic [7:0]  nxt_cmd;
	logic [3:0]  idx_ff;
	logic [3:0]  nxt_idx;
	logic [3:0]  need_ff;
	logic [3:0]  nxt_need;
	logic [7:0]  par_ff [0:7];
	logic [7:0]  nxt_par [0:7];
	logic [7:0]  res_ff [0:9];
	logic [7:0]  nxt_res [0:9];
	logic [7:0]  cyl_ff [0:3];
	logic [7:0]  nxt_cyl [0:3];
	logic [7:0]  spec1_ff, spec2_ff, cfg_ff, pretrk_ff, perp_ff, cnt_ff;
	logic [7:0]  nxt_spec1, nxt_spec2, nxt_cfg, nxt_pretrk, nxt_perp, nxt_cnt;
	logic        lock_ff, nxt_lock;
	logic [1:0]  unit_ff, nxt_unit;
	logic [1:0]  dsel_ff, nxt_dsel;
	logic [3:0]  bsy_ff, nxt_bsy;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        rdy_ff, nxt_rdy;
	logic        err_ff, nxt_err;
	logic [2:0]  flt_sync_ff;
	logic        flt_ff;
	logic        nxt_flt;
	logic        seek_start, seek_busy, seek_done, seek_fail;
	logic [7:0]  seek_cyl;
	logic        setup, wr_data, rd_data, mapped;
	logic [4:0]  op;
	logic        is_xfer;
	logic [7:0]  mst;

	assign setup   = psel_in && !penable_in;
	assign wr_data = setup && pwrite_in && paddr_in == OFS_DATA;
	assign rd_data = setup && !pwrite_in && paddr_in == OFS_DATA;
	assign mapped  = paddr_in == OFS_DATA || paddr_in == OFS_STATUS || paddr_in == OFS_DRVCTL
		|| paddr_in == OFS_SEEKRES || paddr_in == OFS_DRVSTAT;
	assign op      = cmd_ff[4:0];
	// one decode for every transfer code
	assign is_xfer = op == CODE_RD_DATA || op == CODE_RD_DEL || op == CODE_WR_DATA
		|| op == CODE_WR_DEL || op == CODE_RD_TRACK || op == CODE_VER; // RQ4
	always_comb
	begin
		mst          = 8'h00;
		mst[3:0]     = bsy_ff; // RQ7
		mst[MS_BUSY] = phase_ff != S_IDLE;
		mst[MS_DIO]  = phase_ff == S_RESULT;
		mst[MS_RQM]  = phase_ff != S_SEEK;
	end

	seek_unit seek_unit_i
	(
		.clk_in      (clk_in),
		.rst_b_in    (rst_b_in),
		.start_in    (seek_start),
		.from_cyl_in (cyl_ff[unit_ff]),
		.to_cyl_in   (par_ff[1]),
		.fault_in    (flt_ff),
		.busy_out    (seek_busy),
		.done_out    (seek_done),
		.fail_out    (seek_fail),
		.cyl_out     (seek_cyl)
	);

	always_comb
	begin
		nxt_phase  = phase_ff;
		nxt_cmd    = cmd_ff;
		nxt_idx    = idx_ff;
		nxt_need   = need_ff;
		nxt_par    = par_ff;
		nxt_res    = res_ff;
		nxt_cyl    = cyl_ff;
		nxt_spec1  = spec1_ff;
		nxt_spec2  = spec2_ff;
		nxt_cfg    = cfg_ff;
		nxt_pretrk = pretrk_ff;
		nxt_perp   = perp_ff;
		nxt_cnt    = cnt_ff;
		nxt_lock   = lock_ff;
		nxt_unit   = unit_ff;
		nxt_dsel   = dsel_ff;
		nxt_bsy    = bsy_ff;
		nxt_flt    = flt_sync_ff[2] == flt_sync_ff[1] ? flt_sync_ff[1] : flt_ff;
		seek_start = 1'b0;
		nxt_rdy    = setup;
		nxt_err    = setup && !mapped;
		nxt_rdata  = rdata_ff;
		if (setup && !pwrite_in)
		begin
			case (paddr_in)
				OFS_DATA:    nxt_rdata = (phase_ff == S_RESULT) ? {24'h0, res_ff[idx_ff]} : 32'h0;
				OFS_STATUS:  nxt_rdata = {24'h0, mst};
				OFS_DRVCTL:  nxt_rdata = {30'h0, dsel_ff};
				OFS_SEEKRES: nxt_rdata = {24'h0, cyl_ff[unit_ff]};
				OFS_DRVSTAT: nxt_rdata = {29'h0, flt_ff, unit_ff};
				default:     nxt_rdata = 32'h0;
			endcase
		end
		// drive select pins follow only this register
		if (setup && pwrite_in && paddr_in == OFS_DRVCTL)
			nxt_dsel = pwdata_in[1:0]; // RQ2
		case (phase_ff)
			S_IDLE:
			begin
				if (wr_data)
				begin
					nxt_cmd = pwdata_in[7:0];
					nxt_idx = 4'h0;
					nxt_phase = S_PARAM;
					case (pwdata_in[4:0])
						CODE_RD_DATA, CODE_RD_DEL, CODE_WR_DATA, CODE_WR_DEL, CODE_RD_TRACK, CODE_VER:
							nxt_need = XFER_PARAMS; // RQ4
						CODE_READ_ID: nxt_need = READID_PARAMS;
						CODE_CONFIG:  nxt_need = CONFIG_PARAMS;
						CODE_SPECIFY: nxt_need = SPEC_PARAMS;
						CODE_FORMAT:  nxt_need = FMT_PARAMS;
						CODE_DUMP:
						begin
							nxt_res[0] = cyl_ff[0];
							nxt_res[1] = cyl_ff[1];
							nxt_res[2] = cyl_ff[2];
							nxt_res[3] = cyl_ff[3];
							nxt_res[4] = spec1_ff;
							nxt_res[5] = spec2_ff;
							nxt_res[6] = cnt_ff; // RQ1
							nxt_res[7] = {lock_ff, perp_ff[6:0]};
							nxt_res[8] = cfg_ff;
							nxt_res[9] = pretrk_ff;
							nxt_need   = DUMP_RESULTS;
							nxt_phase  = S_RESULT;
						end
						CODE_LOCK:
						begin
							nxt_lock   = pwdata_in[7];
							nxt_res[0] = 8'h00;
							nxt_res[0][LOCK_BIT_POS] = pwdata_in[7]; // RQ11
							nxt_need   = 4'h1;
							nxt_phase  = S_RESULT;
						end
						default:
						begin
							nxt_res[0] = RES0_INVALID; // RQ10
							nxt_need   = 4'h1;
							nxt_phase  = S_RESULT;
						end
					endcase
				end
			end
			S_PARAM:
			begin
				if (wr_data)
				begin
					nxt_par[idx_ff[2:0]] = pwdata_in[7:0];
					nxt_idx = idx_ff + 4'h1;
					if (idx_ff == 4'h0)
						nxt_unit = pwdata_in[1:0]; // RQ2
					if (idx_ff + 4'h1 == need_ff)
					begin
						nxt_idx   = 4'h0;
						nxt_phase = S_RESULT;
						nxt_res[0] = {5'h0, par_ff[0][2], unit_ff};
						nxt_res[1] = 8'h00;
						nxt_res[2] = 8'h00;
						if (is_xfer)
						begin
							nxt_res[3] = par_ff[1];
							nxt_res[4] = par_ff[2];
							nxt_res[5] = par_ff[3];
							nxt_res[6] = par_ff[4];
							nxt_need   = XFER_RESULTS;
							nxt_cnt    = par_ff[5]; // RQ1
							if (cfg_ff[ISEEK_BIT_POS])
							begin
								seek_start = 1'b1; // RQ5
								nxt_bsy[unit_ff] = 1'b1; // RQ7
								nxt_phase = S_SEEK;
							end
						end
						else if (op == CODE_READ_ID)
						begin
							nxt_res[0] = {5'h0, pwdata_in[2], pwdata_in[1:0]};
							nxt_res[3] = cyl_ff[pwdata_in[1:0]]; // RQ9
							nxt_res[4] = {7'h0, pwdata_in[2]};
							nxt_res[5] = 8'h01;
							nxt_res[6] = 8'h02;
							nxt_need   = XFER_RESULTS;
						end
						else
						begin
							nxt_phase = S_IDLE;
							if (op == CODE_CONFIG)
							begin
								nxt_cfg    = par_ff[1];
								nxt_pretrk = pwdata_in[7:0];
							end
							if (op == CODE_SPECIFY)
							begin
								nxt_spec1 = par_ff[0];
								nxt_spec2 = pwdata_in[7:0];
							end
							if (op == CODE_FORMAT)
								nxt_cnt = par_ff[2]; // RQ1
						end
					end
				end
			end
			S_SEEK:
			begin
				// seek finishes on its own, results follow with no host step
				if (seek_done)
				begin
					nxt_bsy[unit_ff] = 1'b0; // RQ6
					nxt_cyl[unit_ff] = seek_cyl;
					nxt_phase = S_RESULT;
					if (seek_fail)
					begin
						nxt_res[0] = RES0_ABNORMAL | {5'h0, par_ff[0][2], unit_ff}; // RQ8
						nxt_res[3] = seek_cyl; // RQ8
					end
				end
			end
			S_RESULT:
			begin
				if (rd_data)
				begin
					nxt_idx = idx_ff + 4'h1;
					if (idx_ff + 4'h1 == need_ff)
					begin
						nxt_idx   = 4'h0;
						nxt_phase = S_IDLE;
					end
				end
			end
			default: nxt_phase = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			phase_ff    <= S_IDLE;
			cmd_ff      <= 8'h00;
			idx_ff      <= 4'h0;
			need_ff     <= 4'h0;
			par_ff      <= '{default: 8'h00};
			res_ff      <= '{default: 8'h00};
			cyl_ff      <= '{default: 8'h00};
			spec1_ff    <= SPEC1_RST;
			spec2_ff    <= SPEC2_RST;
			cfg_ff      <= CFG_RST;
			pretrk_ff   <= PRETRK_RST;
			perp_ff     <= PERP_RST;
			cnt_ff      <= 8'h00;
			lock_ff     <= 1'b0;
			unit_ff     <= 2'h0;
			dsel_ff     <= 2'h0;
			bsy_ff      <= 4'h0;
			rdata_ff    <= 32'h0;
			rdy_ff      <= 1'b0;
			err_ff      <= 1'b0;
			flt_sync_ff <= 3'h0;
			flt_ff      <= 1'b0;
		end
		else
		begin
			phase_ff    <= nxt_phase;
			cmd_ff      <= nxt_cmd;
			idx_ff      <= nxt_idx;
			need_ff     <= nxt_need;
			par_ff      <= nxt_par;
			res_ff      <= nxt_res;
			cyl_ff      <= nxt_cyl;
			spec1_ff    <= nxt_spec1;
			spec2_ff    <= nxt_spec2;
			cfg_ff      <= nxt_cfg;
			pretrk_ff   <= nxt_pretrk;
			perp_ff     <= nxt_perp;
			cnt_ff      <= nxt_cnt;
			lock_ff     <= nxt_lock;
			unit_ff     <= nxt_unit;
			dsel_ff     <= nxt_dsel;
			bsy_ff      <= nxt_bsy;
			rdata_ff    <= nxt_rdata;
			rdy_ff      <= nxt_rdy;
			err_ff      <= nxt_err;
			flt_sync_ff <= {flt_sync_ff[1:0], seek_fault_in};
			flt_ff      <= nxt_flt;
		end
	end

	assign prdata_out       = rdata_ff;
	assign pready_out       = rdy_ff;
	assign pslverr_out      = err_ff;
	assign drive_select_out = dsel_ff;
endmodule
`default_nettype wire

/* File: verification/floppy_cmd_sva.sv */
// assertions on the command engine ports
`timescale 1ns/100ps
`default_nettype none
module floppy_cmd_sva
	import fdc_cmd_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// apb
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [31:0] prdata_out,
	input  wire logic        pready_out,
	input  wire logic        pslverr_out,
	// drive pins
	input  wire logic        seek_fault_in,
	input  wire logic [1:0]  drive_select_out
);
	logic mapped;
	logic wr_dc;
	assign mapped = paddr_in inside {OFS_DATA, OFS_STATUS, OFS_DRVCTL, OFS_SEEKRES, OFS_DRVSTAT};
	assign wr_dc  = psel_in && !penable_in && pwrite_in && paddr_in == OFS_DRVCTL;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	property p_rdy_next; psel_in && !penable_in |=> pready_out; endproperty
	a_rdy_next: assert property (p_rdy_next) else $error("no ready after setup");
	property p_rdy_pulse; pready_out |=> !pready_out; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
	property p_idle; !psel_in |-> !pready_out; endproperty
	a_idle: assert property (p_idle) else $error("ready without select");
	property p_err_map; pready_out && !mapped |-> pslverr_out; endproperty
	a_err_map: assert property (p_err_map) else $error("unmapped access not flagged");
	property p_ok_map; pready_out && mapped |-> !pslverr_out; endproperty
	a_ok_map: assert property (p_ok_map) else $error("mapped access flagged");
	property p_err_zero; pready_out && pslverr_out |-> prdata_out == 32'h0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read not zero");
	property p_byte_wide; pready_out && !pwrite_in && paddr_in == OFS_DATA |-> prdata_out[31:8] == 24'h0; endproperty
	a_byte_wide: assert property (p_byte_wide) else $error("data read upper bits set");
	property p_ds_src; $changed(drive_select_out) |-> $past(wr_dc) || $past(wr_dc, 2) || $past(wr_dc, 3); endproperty
	a_ds_src: assert property (p_ds_src) else $error("select pins moved without control write");
	c_err: cover property (pready_out && pslverr_out);
	c_busy: cover property (pready_out && paddr_in == OFS_STATUS && prdata_out[0]);
	c_ds: cover property ($changed(drive_select_out));
endmodule
`default_nettype wire

/* File: verification/floppy_drive_model.sv */
// floppy drive stand-in: raises the seek fault line on request
`timescale 1ns/100ps
`default_nettype none
module floppy_drive_model
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	// control and pin
	input  wire logic fault_req_in,
	output logic      seek_fault_out
);
	// fault moves off the engine clock edge, as an unrelated drive would
	always @(negedge clk_in or negedge rst_b_in)
		if (!rst_b_in)
			seek_fault_out <= 1'b0;
		else
			seek_fault_out <= fault_req_in;
endmodule
`default_nettype wire

/* File: verification/floppy_cmd_seek_dump_logic_bench.sv */
// self-checking bench for the command engine
`timescale 1ns/100ps
`default_nettype none
module floppy_cmd_seek_dump_logic_bench
	import fdc_cmd_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        psel_in = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic        fault_req = 1'b0;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        seek_fault_in;
	logic [1:0]  drive_select_out;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  cur;
	logic [7:0]  res [0:9];
	logic [4:0]  xc [0:5] = '{CODE_RD_DATA, CODE_RD_DEL, CODE_WR_DATA, CODE_WR_DEL, CODE_RD_TRACK, CODE_VER};
	int          n_mismatch = 0;
	int          compares = 0;
	int          i;
	always #2 clk_in = ~clk_in;
	floppy_cmd_seek_dump_logic floppy_cmd_seek_dump_logic_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.seek_fault_in(seek_fault_in), .drive_select_out(drive_select_out));
	floppy_drive_model floppy_drive_model_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.fault_req_in(fault_req), .seek_fault_out(seek_fault_in));
	task automatic finish_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		for (n = 0; n < 8; n++)
		begin
			@(posedge clk_in);
			if (pready_out === 1'b1)
				break;
		end
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (n == 8)
		begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic wait_rqm;
		int n;
		for (n = 0; n < 400; n++)
		begin
			apb(1'b0, OFS_STATUS, 32'h0);
			if (rd[MS_RQM] === 1'b1)
				break;
		end
		if (n == 400)
		begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic wr_b(input logic [7:0] b);
		wait_rqm();
		apb(1'b1, OFS_DATA, {24'h0, b});
	endtask
	task automatic rd_res(input int n);
		for (int k = 0; k < n; k++)
		begin
			wait_rqm();
			chk(rd[MS_DIO], 1'b1);
			apb(1'b0, OFS_DATA, 32'h0);
			res[k] = rd[7:0];
		end
		wait_rqm();
		chk(rd[MS_DIO], 1'b0);
	endtask
	task automatic xfer(input logic [4:0] code, input logic [7:0] cyl, input logic [7:0] last_sec, input logic busy);
		logic [7:0] p [0:7];
		p = '{8'h00, cyl, 8'h00, 8'h01, 8'h02, last_sec, 8'h1b, 8'hff};
		wr_b({3'h0, code});
		foreach (p[k])
			wr_b(p[k]);
		if (busy)
		begin
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(rd[0], 1'b1);
			chk(rd[MS_RQM], 1'b0);
		end
		rd_res(7);
	endtask
	initial
	begin
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'b1;
		apb(1'b1, OFS_DRVCTL, 32'h0);
		wr_b(8'h1f);
		rd_res(1);
		chk(res[0], RES0_INVALID);
		for (i = 0; i < 2; i++)
		begin
			wr_b({i[0], 2'b00, CODE_LOCK});
			rd_res(1);
			chk(res[0], {3'h0, i[0], 4'h0});
		end
		wr_b({3'h0, CODE_CONFIG});
		wr_b(8'h00);
		wr_b(8'h40);
		wr_b(8'h00);
		for (i = 0; i < 6; i++)
		begin
			cur = {6'h00, ~i[0], 1'b0};
			xfer(xc[i], cur, 8'(i + 16), 1'b1);
			chk(res[0][7:6], 2'b00);
			chk({res[1], res[2]}, 16'h0);
			apb(1'b0, OFS_SEEKRES, 32'h0);
			chk(rd[7:0], cur);
		end
		wr_b({3'h0, CODE_DUMP});
		rd_res(10);
		chk(res[0], cur);
		chk(res[6], 8'h15);
		fault_req <= 1'b1;
		repeat (8) @(posedge clk_in);
		xfer(CODE_RD_DATA, 8'h05, 8'h12, 1'b0);
		chk(res[0][6], 1'b1);
		chk(res[3], cur);
		fault_req <= 1'b0;
		wr_b({3'h0, CODE_FORMAT});
		wr_b(8'h00);
		wr_b(8'h02);
		wr_b(8'h09);
		wr_b(8'h54);
		wr_b(8'he5);
		wait_rqm();
		chk(rd[MS_DIO], 1'b0);
		chk(rd[MS_BUSY], 1'b0);
		wr_b({3'h0, CODE_DUMP});
		rd_res(10);
		chk(res[6], 8'h09);
		apb(1'b1, OFS_DRVCTL, 32'h2);
		repeat (3) @(posedge clk_in);
		chk(drive_select_out, 2'h2);
		wr_b(8'h4a);
		wr_b(8'h01);
		rd_res(7);
		chk({res[3], res[5], res[6]}, 24'h000102);
		chk(drive_select_out, 2'h2);
		apb(1'b0, OFS_DRVSTAT, 32'h0);
		chk(rd[1:0], 2'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk({er, rd}, 33'h100000000);
		finish_test();
	end
endmodule
bind floppy_cmd_seek_dump_logic floppy_cmd_sva floppy_cmd_sva_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.seek_fault_in(seek_fault_in), .drive_select_out(drive_select_out));
`default_nettype wire
